// ===== hdl/afsr_pkg.sv
// afsr_pkg: constants and carrier types for the restart/ready control
// assumes a single 50 MHz clock; all rates derived from it by enables
package afsr_pkg;

    localparam int CLK_HZ           = 50_000_000;
    // master clock period in ns
    localparam int CLK_PERIOD_NS    = 20;
    // default output-rate divider (cycles per output word)
    localparam int OUT_DIV_DEF      = 1000;
    // settling length in output-rate periods
    localparam int SETTLE_PERIODS   = 3;
    // high pulse on update with unread word, in master clock periods
    localparam int READY_PULSE_CYC  = 500;
    localparam int PULSE_W          = 10;
    localparam int DIV_W            = 16;
    localparam int SETTLE_W         = 2;
    localparam logic [PULSE_W-1:0] PULSE_RST = 10'h000;
    localparam logic [DIV_W-1:0]   DIV_RST   = 16'h0000;
    localparam logic [SETTLE_W-1:0] SETTLE_RST = 2'h0;

    typedef enum logic [1:0] {
        AFSR_HOLD   = 2'b00,
        AFSR_SETTLE = 2'b01,
        AFSR_RUN    = 2'b11
    } afsr_state_e;

    // host-side control inputs, on the same clock
    typedef struct packed {
        logic restart_bit;
        logic data_read;
    } afsr_ctrl_s;

    // filter-side control outputs
    typedef struct packed {
        logic filter_clear;
        logic word_load;
        logic sample_en;
    } afsr_filt_s;

endpackage

// ===== hdl/afsr_sync.sv
// afsr_sync: two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to clk
module afsr_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic rst_val,
    input  wire logic din,
    output logic      dout
);
    logic meta_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b1;
            dout   <= 1'b1;
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
    // rst_val kept for width symmetry; pins idle high
    logic unused_rst_val;
    assign unused_rst_val = rst_val;
endmodule

// ===== hdl/afsr_rate.sv
// afsr_rate: output-rate enable divider derived from the master clock
// assumes clr holds the count at zero while the filter is held
module afsr_rate #(
    parameter int DIV = 1000
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clr,
    output logic      tick
);
    import afsr_pkg::*;
    logic [DIV_W-1:0] cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= DIV_RST;
        end else if (clr) begin
            cnt_r <= DIV_RST;
        end else if (cnt_r == DIV_W'(DIV - 1)) begin
            cnt_r <= DIV_RST;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
    assign tick = !clr && (cnt_r == DIV_W'(DIV - 1));
endmodule

// ===== hdl/afsr_ctrl.sv
// afsr_ctrl: filter restart, reset and result-ready control
// assumes pins come from outside; restart bit and read strobe are
// produced on CLK by the serial port logic
module afsr_ctrl #(
    parameter int OUT_DIV = afsr_pkg::OUT_DIV_DEF
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RESET,
    // pins
    input  wire logic              RESTART_PIN_N,
    input  wire logic              RESET_PIN_N,
    // host-side controls on CLK
    input  wire afsr_pkg::afsr_ctrl_s CTRL,
    // status toward host
    output logic                   RESULT_READY_N,
    output logic                   ACCESS_EN,
    output logic                   MCLK_OUT,
    // filter and modulator control
    output afsr_pkg::afsr_filt_s   FILT
);
    import afsr_pkg::*;

    typedef struct packed {
        afsr_state_e          state;
        logic [SETTLE_W-1:0]  settle;
        logic [PULSE_W-1:0]   pulse;
        logic                 unread;
        logic                 ready_n;
        logic                 pin_d;
        logic                 clear;
        logic                 load;
    } afsr_st_s;

    afsr_st_s st_r;
    afsr_st_s st_nxt;
    logic     restart_s;
    logic     reset_s;
    logic     hold;
    logic     tick;

    afsr_sync u_sync_restart (
        .clk     (CLK),
        .rst     (RESET),
        .rst_val (1'b1),
        .din     (RESTART_PIN_N),
        .dout    (restart_s)
    );
    afsr_sync u_sync_reset (
        .clk     (CLK),
        .rst     (RESET),
        .rst_val (1'b1),
        .din     (RESET_PIN_N),
        .dout    (reset_s)
    );

    // hold while pin low or bit high
    assign hold = !restart_s || CTRL.restart_bit;

    // output rate derived from clk; cleared while held
    afsr_rate #(
        .DIV (OUT_DIV)
    ) u_rate (
        .clk  (CLK),
        .rst  (RESET),
        .clr  (hold || !reset_s),
        .tick (tick)
    );

    always_comb begin
        st_nxt       = st_r;
        st_nxt.pin_d = restart_s;
        st_nxt.clear = 1'b0;
        st_nxt.load  = 1'b0;
        if (!reset_s) begin
            st_nxt         = '0;
            st_nxt.state   = AFSR_SETTLE;
            st_nxt.settle  = SETTLE_RST;
            st_nxt.pulse   = PULSE_RST;
            st_nxt.ready_n = 1'b1;
            st_nxt.pin_d   = restart_s;
            st_nxt.clear   = 1'b1;
        end else begin
            if (CTRL.data_read) begin
                st_nxt.ready_n = 1'b1;
                st_nxt.unread  = 1'b0;
                st_nxt.pulse   = PULSE_RST;
            end
            case (st_r.state)
                AFSR_HOLD: begin
                    // release resumes on next edge; clear drops at once
                    // so sampling restarts on the edge that sees release
                    if (!hold) begin
                        st_nxt.state  = AFSR_SETTLE;
                        st_nxt.settle = SETTLE_RST;
                    end
                end
                AFSR_SETTLE: begin
                    if (tick) begin
                        if (st_r.settle == SETTLE_W'(SETTLE_PERIODS - 1))
                        begin
                            st_nxt.state = AFSR_RUN;
                            st_nxt.load  = 1'b1;
                        end else begin
                            st_nxt.settle = st_r.settle + 1'b1;
                        end
                    end
                end
                AFSR_RUN: begin
                    if (tick) begin
                        st_nxt.load = 1'b1;
                    end
                end
                default: begin
                    st_nxt.state = AFSR_HOLD;
                end
            endcase
            // word load ends a conversion with ready falling, or with a high pulse if ready is already low on an unread word
            if (st_nxt.load) begin
                st_nxt.unread = 1'b1;
                if (st_r.unread && !st_r.ready_n && !CTRL.data_read)
                begin
                    st_nxt.ready_n = 1'b1;
                    st_nxt.pulse   = PULSE_W'(READY_PULSE_CYC);
                end else begin
                    st_nxt.ready_n = 1'b0;
                end
            end else if (st_r.pulse != PULSE_RST && !CTRL.data_read) begin
                // a read cancels a running pulse, ready stays high
                st_nxt.pulse = st_r.pulse - 1'b1;
                if (st_r.pulse == PULSE_W'(1)) begin
                    st_nxt.ready_n = 1'b0;
                end
            end
            // entry on pin fall or bit set; a running pulse ends with ready high
            // an unread word keeps ready low across restart
            if (hold) begin
                st_nxt.state  = AFSR_HOLD;
                st_nxt.settle = SETTLE_RST;
                st_nxt.load   = 1'b0;
                st_nxt.clear  = 1'b1;
                if (st_r.pulse != PULSE_RST) begin
                    st_nxt.pulse   = PULSE_RST;
                    st_nxt.ready_n = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            st_r         <= '0;
            st_r.state   <= AFSR_SETTLE;
            st_r.ready_n <= 1'b1;
            st_r.pin_d   <= 1'b1;
            st_r.clear   <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RESULT_READY_N   = st_r.ready_n;
    assign ACCESS_EN        = reset_s;
    // master clock passed out, independent of reset
    assign MCLK_OUT         = CLK;
    assign FILT.filter_clear = st_r.clear;
    assign FILT.word_load    = st_r.load;
    assign FILT.sample_en    = !st_r.clear;
endmodule

// ===== test/afsr_ctrl_checker.sv
// afsr_ctrl_checker: timing checks on the restart and ready ports
// assumes it is bound to afsr_ctrl; single clock domain
module afsr_ctrl_checker #(
    parameter int OUT_DIV = afsr_pkg::OUT_DIV_DEF
) (
    input wire logic                 CLK,
    input wire logic                 RESET,
    input wire logic                 RESTART_PIN_N,
    input wire logic                 RESET_PIN_N,
    input wire afsr_pkg::afsr_ctrl_s CTRL,
    input wire logic                 RESULT_READY_N,
    input wire logic                 ACCESS_EN,
    input wire logic                 MCLK_OUT,
    input wire afsr_pkg::afsr_filt_s FILT
);
    timeunit 1ns;
    timeprecision 1ns;
    import afsr_pkg::*;
    int hi_cnt;
    int run_cnt;
    // counters stand in for long repetitions the tools cannot unroll
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            hi_cnt <= 0;
            run_cnt <= 0;
        end else begin
            hi_cnt <= RESULT_READY_N ? hi_cnt + 1 : 0;
            run_cnt <= FILT.filter_clear ? 0 : run_cnt + 1;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    a_bit_holds: assert property (
        CTRL.restart_bit |=> FILT.filter_clear) else $error("not held");
    a_bit_release: assert property (
        (RESTART_PIN_N && RESET_PIN_N)[*3] ##0 $fell(CTRL.restart_bit)
        |=> !FILT.filter_clear) else $error("not released");
    a_pin_rst_clear: assert property (
        !RESET_PIN_N[*4] |-> FILT.filter_clear && !FILT.word_load)
        else $error("filter not cleared in reset");
    a_pin_rst_ready: assert property (
        !RESET_PIN_N[*4] |-> RESULT_READY_N && !ACCESS_EN)
        else $error("ready or access wrong in reset");
    a_sample_inverse: assert property (
        FILT.sample_en != FILT.filter_clear) else $error("sample enable");
    a_settle_wait: assert property (
        FILT.word_load |-> run_cnt >= 3 * OUT_DIV - 3)
        else $error("word loaded before settling");
    a_read_clears: assert property (
        CTRL.data_read && !FILT.word_load ##1 !FILT.word_load
        |-> RESULT_READY_N) else $error("read left ready low");
    a_pulse_len: assert property (
        $fell(RESULT_READY_N) && !FILT.word_load && !$past(FILT.word_load)
        |-> hi_cnt == READY_PULSE_CYC) else $error("ready fell early");
    a_mclk_runs: assert property (
        @(negedge CLK) disable iff (RESET) MCLK_OUT) else $error("mclk");
    c_load: cover property (FILT.word_load);
    c_pulse: cover property ($fell(RESULT_READY_N) && !FILT.word_load);
    c_pin_rst: cover property (!RESET_PIN_N[*4]);
endmodule

bind afsr_ctrl afsr_ctrl_checker #(.OUT_DIV(OUT_DIV)) chk_u (
    .CLK(CLK), .RESET(RESET), .RESTART_PIN_N(RESTART_PIN_N),
    .RESET_PIN_N(RESET_PIN_N), .CTRL(CTRL), .RESULT_READY_N(RESULT_READY_N),
    .ACCESS_EN(ACCESS_EN), .MCLK_OUT(MCLK_OUT), .FILT(FILT));

// ===== test/afsr_host.sv
// afsr_host: host that drives the restart and reset pins and reads
// assumes the bench sets wanted levels; reads are one-cycle strobes
module afsr_host (
    // bench requests, plus ready status from the block
    input  wire logic            clk,
    input  wire logic            want_pin_n,
    input  wire logic            want_rst_n,
    input  wire logic            want_bit,
    input  wire logic            auto_read,
    input  wire logic            ready_n,
    // toward the block
    output logic                 restart_pin_n,
    output logic                 reset_pin_n,
    output afsr_pkg::afsr_ctrl_s ctrl
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        restart_pin_n = 1'b1;
        reset_pin_n = 1'b1;
        ctrl = '0;
    end
    // restarts only on command from the bench
    always @(posedge clk) begin
        restart_pin_n <= want_pin_n;
        reset_pin_n <= want_rst_n;
        ctrl.restart_bit <= want_bit;
        ctrl.data_read <= auto_read && ready_n === 1'b0 && !ctrl.data_read;
    end
endmodule

// ===== test/tb_top.sv
// tb_top: scenarios for restart, reset and result-ready control
// assumes design, host model and bound checker compiled before it
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import afsr_pkg::*;
    // output period must exceed the 500-clock ready pulse
    localparam int DIV = 600;
    logic       clk = 0, rst = 1, want_bit = 0, auto_read = 0;
    logic       want_pin_n = 1, want_rst_n = 1;
    logic       restart_pin_n, reset_pin_n, ready_n, access_en, mclk_out;
    afsr_ctrl_s ctrl;
    afsr_filt_s filt;
    int         err_total = 0, compares = 0, n;
    initial forever #10 clk = ~clk;
    afsr_ctrl #(.OUT_DIV(DIV)) dut_u (.CLK(clk), .RESET(rst),
        .RESTART_PIN_N(restart_pin_n), .RESET_PIN_N(reset_pin_n),
        .CTRL(ctrl), .RESULT_READY_N(ready_n), .ACCESS_EN(access_en),
        .MCLK_OUT(mclk_out), .FILT(filt));
    afsr_host host_u (.clk(clk), .want_pin_n(want_pin_n),
        .want_rst_n(want_rst_n), .want_bit(want_bit), .auto_read(auto_read),
        .ready_n(ready_n), .restart_pin_n(restart_pin_n),
        .reset_pin_n(reset_pin_n), .ctrl(ctrl));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // bounded wait, counted in whole cycles
    task automatic wait_rdy(input logic val);
        n = 0;
        while (ready_n !== val) begin
            @(negedge clk);
            n++;
            if (n > 4000) begin
                err_total++;
                close_out();
            end
        end
    endtask
    function automatic logic [15:0] in_win(input int lo);
        return 16'(n >= lo && n <= lo + 10);
    endfunction
    task automatic t_pulse();
        wait_rdy(1'b1);
        check(16'(n <= DIV + 2), 16'h0001);
        wait_rdy(1'b0);
        check(16'(n), 16'(READY_PULSE_CYC));
    endtask
    task automatic t_bit();
        @(posedge clk) want_bit <= 1'b1;
        repeat (4) @(negedge clk);
        check(16'({filt.filter_clear, ready_n}), 16'h0002);
        @(posedge clk) want_bit <= 1'b0;
        repeat (3) @(negedge clk);
        check(16'({filt.filter_clear, ready_n}), 16'h0000);
        wait_rdy(1'b1);
        check(in_win(3 * DIV - 3), 16'h0001);
        wait_rdy(1'b0);
    endtask
    task automatic t_pin();
        @(posedge clk) want_pin_n <= 1'b0;
        repeat (6) @(negedge clk);
        check(16'({filt.filter_clear, ready_n}), 16'h0002);
        @(posedge clk) auto_read <= 1'b1;
        wait_rdy(1'b1);
        check(16'(n <= 4), 16'h0001);
        @(posedge clk) auto_read <= 1'b0;
        repeat (DIV) @(negedge clk);
        check(16'(ready_n), 16'h0001);
        @(posedge clk) want_pin_n <= 1'b1;
        wait_rdy(1'b0);
        check(in_win(3 * DIV), 16'h0001);
    endtask
    task automatic t_reset();
        @(posedge clk) want_rst_n <= 1'b0;
        repeat (6) @(negedge clk);
        check(16'({ready_n, access_en}), 16'h0002);
        check(16'(filt.filter_clear), 16'h0001);
        #1;
        check(16'(mclk_out), 16'(clk));
        #10;
        check(16'(mclk_out), 16'(clk));
        @(posedge clk) want_rst_n <= 1'b1;
        wait_rdy(1'b0);
        check(in_win(3 * DIV), 16'h0001);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wait_rdy(1'b0);
        check(in_win(3 * DIV), 16'h0001);
        t_pulse();
        t_bit();
        t_pin();
        t_reset();
        close_out();
    end
endmodule
